// ### src/wsw_pkg.sv
// constants and types shared by the windowed service watchdog
// assumes a 32-bit apb slave port and a 100 MHz bus clock
package wsw_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 18;

  // register byte offsets
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_OPT1   = 12'h004;
  localparam logic [11:0] OFF_OPT2   = 12'h008;
  localparam logic [11:0] OFF_COUNT  = 12'h00C;

  // service values written to the reset-status address
  localparam logic [15:0] SVC_ARM  = 16'h0055;
  localparam logic [15:0] SVC_DONE = 16'h00AA;

  // field positions
  localparam int unsigned TSEL_POS      = 0;
  localparam int unsigned CLKS_POS      = 0;
  localparam int unsigned WIN_POS       = 1;
  localparam int unsigned WDOG_FLAG_POS = 5;

  // reset values and the timeout select that disables
  localparam logic [1:0] TSEL_RST = 2'h3;
  localparam logic [1:0] TSEL_OFF = 2'h0;
  localparam logic       CLKS_RST = 1'b0;
  localparam logic       WIN_RST  = 1'b0;

  // last count before overflow, 1 kHz source: 2^5, 2^8, 2^10
  localparam logic [CNT_W-1:0] LPO_LAST_1 = 18'h0001F;
  localparam logic [CNT_W-1:0] LPO_LAST_2 = 18'h000FF;
  localparam logic [CNT_W-1:0] LPO_LAST_3 = 18'h003FF;
  // bus source: 2^13, 2^16, 2^18
  localparam logic [CNT_W-1:0] BUS_LAST_1 = 18'h01FFF;
  localparam logic [CNT_W-1:0] BUS_LAST_2 = 18'h0FFFF;
  localparam logic [CNT_W-1:0] BUS_LAST_3 = 18'h3FFFF;
  // window opening counts: 6144, 49152, 196608
  localparam logic [CNT_W-1:0] WIN_OPEN_1 = 18'h01800;
  localparam logic [CNT_W-1:0] WIN_OPEN_2 = 18'h0C000;
  localparam logic [CNT_W-1:0] WIN_OPEN_3 = 18'h30000;

  typedef enum logic [0:0] {
    SEQ_IDLE  = 1'b0,
    SEQ_ARMED = 1'b1
  } wsw_seq_t;

endpackage

// ### src/wsw_top.sv
// windowed service watchdog with apb register access
// assumes apb master on clk; lpo_clk is a free 1 kHz pin, synchronised here;
// stop_mode, debug_mode and other_reset come from logic on clk
//
// What this block does
// R1: watchdog runs after every reset without any software action.
// R2: timeout select of zero disables the watchdog whatever the clock select.
// R3: writing 0x55 then 0xAA to reset-status address restarts the timeout.
// R4: service writes never alter the read-only reset-status contents.
// R5: missing the service before timeout issues a system reset.
// R6: any other value in the low 16 bits written to reset-status resets the system at once.
// R7: clock select 0 counts 1 kHz ticks, 1 counts bus cycles.
// R8: 1 kHz timeouts are 2^5, 2^8, 2^10 ticks.
// R9: bus timeouts are 2^13, 2^16, 2^18 cycles.
// R10: defaults are 1 kHz source with the 2^10 timeout.
// R11: bus clock with window enabled rejects service before last quarter.
// R12: window opens at 6144, 49152 or 196608 bus cycles.
// R13: window mode never applies with the 1 kHz source.
// R14: first write to each options register fixes settings and clears counter.
// R15: software writes both options registers during initialisation.
// R16: software keeps the service sequence out of interrupt handlers.
// R17: bus source: counter holds in stop or debug mode, then resumes.
// R18: 1 kHz source: counter cleared in stop or debug, restarts from zero.
// R19: a watchdog reset sets a cause flag in reset-status.
// R20: 0xAA not directly after 0x55 does not restart the timeout.
`timescale 1ns/1ps
`default_nettype none

module wsw_top (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [wsw_pkg::ADDR_W-1:0] paddr,
  input  wire logic [wsw_pkg::DATA_W-1:0] pwdata,
  output logic      [wsw_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       lpo_clk,
  input  wire logic                       stop_mode,
  input  wire logic                       debug_mode,
  input  wire logic                       other_reset,
  output logic                            wdog_reset
);
  import wsw_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic [1:0]        tsel;
    logic              clks;
    logic              win;
    logic              lock1;
    logic              lock2;
    wsw_seq_t          seq;
    logic              wd_flag;
    logic              rst_out;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              lpo_s1;
    logic              lpo_s2;
    logic              lpo_s3;
  } wsw_state_t;

  wsw_state_t s_q;
  wsw_state_t s_d;

  function automatic logic [CNT_W-1:0] last_count(input logic [1:0] sel, input logic bus);
    case (sel)
      2'h1:    last_count = bus ? BUS_LAST_1 : LPO_LAST_1;
      2'h2:    last_count = bus ? BUS_LAST_2 : LPO_LAST_2;
      default: last_count = bus ? BUS_LAST_3 : LPO_LAST_3;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] win_open(input logic [1:0] sel);
    case (sel)
      2'h1:    win_open = WIN_OPEN_1;
      2'h2:    win_open = WIN_OPEN_2;
      default: win_open = WIN_OPEN_3;
    endcase
  endfunction

  logic             enabled;
  logic             tick;
  logic             held;
  logic             wr_done;
  logic             wr_srs;
  logic             is_arm;
  logic             is_done;
  logic             early;
  logic             bad_val;
  logic             timeout;
  logic             fire;
  logic [CNT_W-1:0] last_c;

  always_comb begin
    enabled = (s_q.tsel != TSEL_OFF); // [R2]
    // bus source counts every cycle, 1 kHz source on a synchronised rising edge
    tick    = s_q.clks ? 1'b1 : (s_q.lpo_s2 & ~s_q.lpo_s3); // [R7]
    held    = stop_mode | debug_mode;
    last_c  = last_count(s_q.tsel, s_q.clks); // [R8] [R9]
    // a write takes effect only at the edge that completes the access
    wr_done = psel & penable & pwrite & s_q.pready;
    wr_srs  = wr_done & (paddr == OFF_STATUS);
    is_arm  = (pwdata[15:0] == SVC_ARM);
    is_done = (pwdata[15:0] == SVC_DONE);
    bad_val = wr_srs & ~is_arm & ~is_done; // [R6]
    // window only exists on the bus clock
    early   = wr_srs & (is_arm | is_done) & s_q.clks & s_q.win
              & (s_q.cnt < win_open(s_q.tsel)); // [R11] [R12] [R13]
    timeout = tick & ~held & (s_q.cnt == last_c); // [R5]
    fire    = enabled & (timeout | bad_val | early);
  end

  always_comb begin
    s_d         = s_q;
    s_d.lpo_s1  = lpo_clk;
    s_d.lpo_s2  = s_q.lpo_s1;
    s_d.lpo_s3  = s_q.lpo_s2;
    s_d.rst_out = 1'b0;

    // counter
    if (enabled) begin
      if (held) begin
        if (!s_q.clks) begin
          s_d.cnt = '0; // [R18]
        end
        // bus source simply holds its count [R17]
      end else if (tick) begin
        s_d.cnt = s_q.cnt + 18'h00001;
      end
    end

    // service sequence
    if (wr_srs && enabled && !early) begin
      if (is_arm) begin
        s_d.seq = SEQ_ARMED;
      end else if (is_done && s_q.seq == SEQ_ARMED) begin
        s_d.cnt = '0; // [R3]
        s_d.seq = SEQ_IDLE;
      end else begin
        s_d.seq = SEQ_IDLE; // [R20]
      end
    end

    // write-once options, first write also clears the counter
    if (wr_done && paddr == OFF_OPT1 && !s_q.lock1) begin
      s_d.tsel  = pwdata[TSEL_POS +: 2]; // [R14]
      s_d.lock1 = 1'b1;
      s_d.cnt   = '0;
      s_d.seq   = SEQ_IDLE;
    end
    if (wr_done && paddr == OFF_OPT2 && !s_q.lock2) begin
      s_d.clks  = pwdata[CLKS_POS]; // [R14]
      s_d.win   = pwdata[WIN_POS];
      s_d.lock2 = 1'b1;
      s_d.cnt   = '0;
      s_d.seq   = SEQ_IDLE;
    end

    // any reset brings back an armed watchdog with default settings
    if (fire || other_reset) begin
      s_d.tsel  = TSEL_RST; // [R1] [R10]
      s_d.clks  = CLKS_RST;
      s_d.win   = WIN_RST;
      s_d.lock1 = 1'b0;
      s_d.lock2 = 1'b0;
      s_d.cnt   = '0;
      s_d.seq   = SEQ_IDLE;
    end
    if (fire) begin
      s_d.rst_out = 1'b1; // [R5] [R6] [R11]
      s_d.wd_flag = 1'b1; // [R19]
    end else if (other_reset) begin
      // cause flag names only the most recent reset
      s_d.wd_flag = 1'b0;
    end

    // apb: one wait state, answer registered
    s_d.pready  = psel & penable & ~s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata  = '0;
    if (psel && penable && !s_q.pready) begin
      case (paddr)
        OFF_STATUS: s_d.prdata[WDOG_FLAG_POS] = s_q.wd_flag; // [R4]
        OFF_OPT1:   s_d.prdata[TSEL_POS +: 2] = s_q.tsel;
        OFF_OPT2: begin
          s_d.prdata[CLKS_POS] = s_q.clks;
          s_d.prdata[WIN_POS]  = s_q.win;
        end
        OFF_COUNT:  s_d.prdata[CNT_W-1:0] = s_q.cnt;
        default:    s_d.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q         <= '0;
      s_q.tsel    <= TSEL_RST; // [R1] [R10]
      s_q.clks    <= CLKS_RST;
      s_q.win     <= WIN_RST;
      s_q.seq     <= SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign wdog_reset = s_q.rst_out;

  // checks

  sequence s_pulse;
    s_q.rst_out ##1 !s_q.rst_out;
  endsequence

  sequence s_armed_done;
    (s_q.seq == SEQ_ARMED) && wr_srs && is_done && !early && !other_reset;
  endsequence

  property p_defaults_after_fire;
    @(posedge clk) disable iff (!nrst)
      $rose(s_q.rst_out) |-> s_q.tsel == TSEL_RST && !s_q.clks && !s_q.lock1;
  endproperty
  a_defaults_after_fire: assert property (p_defaults_after_fire) // [R1] [R10]
    else $error("defaults not restored after watchdog reset");

  property p_disabled_idle;
    @(posedge clk) disable iff (!nrst)
      (s_q.tsel == TSEL_OFF) && !wr_done && !other_reset
      |=> s_q.cnt == $past(s_q.cnt) && !s_q.rst_out;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) // [R2]
    else $error("disabled watchdog moved or fired");

  property p_service_restart;
    @(posedge clk) disable iff (!nrst)
      ((enabled && !timeout) and s_armed_done) |=> s_q.cnt == '0 && !s_q.rst_out;
  endproperty
  a_service_restart: assert property (p_service_restart) // [R3]
    else $error("completed service did not restart the counter");

  property p_status_unchanged;
    @(posedge clk) disable iff (!nrst)
      wr_srs && !fire && !other_reset |=> s_q.wd_flag == $past(s_q.wd_flag);
  endproperty
  a_status_unchanged: assert property (p_status_unchanged) // [R4]
    else $error("service write altered reset status");

  property p_timeout_fires;
    @(posedge clk) disable iff (!nrst)
      enabled && tick && !held && s_q.cnt == last_c |=> s_pulse;
  endproperty
  a_timeout_fires: assert property (p_timeout_fires) // [R5] [R8] [R9]
    else $error("overflow did not give a one-cycle reset");

  property p_bad_value;
    @(posedge clk) disable iff (!nrst)
      enabled && bad_val |=> s_q.rst_out && s_q.wd_flag;
  endproperty
  a_bad_value: assert property (p_bad_value) // [R6] [R19]
    else $error("illegal service value did not reset");

  property p_early_service;
    @(posedge clk) disable iff (!nrst)
      enabled && wr_srs && (is_arm || is_done) && s_q.clks && s_q.win
      && s_q.cnt < win_open(s_q.tsel) |=> s_q.rst_out;
  endproperty
  a_early_service: assert property (p_early_service) // [R11] [R12]
    else $error("early service in window mode not punished");

  property p_no_window_lpo;
    @(posedge clk) disable iff (!nrst)
      enabled && !s_q.clks && wr_srs && (is_arm || is_done) && !timeout
      |=> !s_q.rst_out;
  endproperty
  a_no_window_lpo: assert property (p_no_window_lpo) // [R13]
    else $error("window applied on 1 kHz source");

  property p_write_once;
    @(posedge clk) disable iff (!nrst)
      s_q.lock1 && !fire && !other_reset |=> s_q.tsel == $past(s_q.tsel);
  endproperty
  a_write_once: assert property (p_write_once) // [R14]
    else $error("locked timeout select changed");

  property p_bus_hold;
    @(posedge clk) disable iff (!nrst)
      enabled && s_q.clks && held && !wr_done && !other_reset
      |=> s_q.cnt == $past(s_q.cnt);
  endproperty
  a_bus_hold: assert property (p_bus_hold) // [R17]
    else $error("bus counter moved in stop or debug");

  property p_lpo_clear;
    @(posedge clk) disable iff (!nrst)
      enabled && !s_q.clks && held |=> s_q.cnt == '0;
  endproperty
  a_lpo_clear: assert property (p_lpo_clear) // [R18]
    else $error("1 kHz counter not cleared in stop or debug");

  property p_lone_done;
    @(posedge clk) disable iff (!nrst)
      enabled && (s_q.seq == SEQ_IDLE) && wr_srs && is_done && !held && !fire
      && !other_reset && s_q.cnt != '0 |=> s_q.cnt != '0;
  endproperty
  a_lone_done: assert property (p_lone_done) // [R20]
    else $error("lone 0xAA restarted the counter");

endmodule // wsw_top

`default_nettype wire

// ### testbench/windowed_service_watchdog_tb.sv
// self-checking bench for the windowed service watchdog, apb master inside
// assumes wsw_pkg offsets and the one-wait-state apb answer of wsw_top
`timescale 1ns/1ps
`default_nettype none

module windowed_service_watchdog_tb;
  import wsw_pkg::*;

  logic              clk         = 1'b0;
  logic              nrst        = 1'b0;
  logic              psel        = 1'b0;
  logic              penable     = 1'b0;
  logic              pwrite      = 1'b0;
  logic [ADDR_W-1:0] paddr       = '0;
  logic [DATA_W-1:0] pwdata      = '0;
  logic              lpo_clk     = 1'b0;
  logic              stop_mode   = 1'b0;
  logic              debug_mode  = 1'b0;
  logic              other_reset = 1'b0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              wdog_reset;
  logic [31:0]       r;
  logic [31:0]       v;
  logic              e;
  int                errors      = 0;
  int                checked     = 0;
  int                fires       = 0;
  int                seed        = 23;
  int                d;
  int                f;

  wsw_top wsw_top_inst (
    .clk         (clk),
    .nrst        (nrst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .lpo_clk     (lpo_clk),
    .stop_mode   (stop_mode),
    .debug_mode  (debug_mode),
    .other_reset (other_reset),
    .wdog_reset  (wdog_reset)
  );

  always #5 clk = ~clk;
  // slow tick stand-in: 40 bus cycles per period keeps lpo timeouts short
  always #200 lpo_clk = ~lpo_clk;
  always @(posedge clk) begin
    if (wdog_reset === 1'b1) fires <= fires + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // count to the last value, one cycle to fire, two more to see it counted
  function automatic int bus_wait(input logic [CNT_W-1:0] last);
    return int'(last) + 3;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wait_fire(output int n);
    int f0;
    f0 = fires;
    n = 0;
    while (fires == f0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic fire_next(input string nm);
    // pulse stands only in the cycle after the completing edge
    #1;
    chk(nm, wdog_reset, 1'b1);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, OFF_OPT1, 32'h0);
    chk("opt1_default", r[1:0], TSEL_RST);
    chk("mapped_ok", e, 1'b0);
    apb(1'b0, OFF_OPT2, 32'h0);
    chk("opt2_default", r[1:0], {WIN_RST, CLKS_RST});
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      apb(v[0], {v[11:4] | 8'h01, 4'h0}, v);
      chk("unmapped_err", e, 1'b1);
    end
    idle(200);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("runs_unarmed", r != 0, 1'b1);
    apb(1'b1, OFF_OPT1, 32'h1);
    apb(1'b1, OFF_OPT2, 32'h1);
    apb(1'b1, OFF_OPT1, 32'h0);
    apb(1'b0, OFF_OPT1, 32'h0);
    chk("opt1_locked", r[1:0], 2'h1);
    apb(1'b0, OFF_COUNT, 32'h0);
    v = r;
    apb(1'b1, OFF_STATUS, {16'h0, SVC_DONE});
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("lone_done", r > v, 1'b1);
    apb(1'b1, OFF_STATUS, {16'h0, SVC_ARM});
    apb(1'b0, OFF_OPT2, 32'h0);
    apb(1'b1, OFF_STATUS, {16'h0, SVC_DONE});
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("restart", r < 16, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status_ro", r, 32'h0);
    for (int m = 0; m < 2; m++) begin
      {debug_mode, stop_mode} <= (m == 0) ? 2'b01 : 2'b10;
      idle(3);
      apb(1'b0, OFF_COUNT, 32'h0);
      v = r;
      idle(200);
      apb(1'b0, OFF_COUNT, 32'h0);
      chk("held", r, v);
      {debug_mode, stop_mode} <= 2'b00;
      idle(50);
      apb(1'b0, OFF_COUNT, 32'h0);
      chk("resumed", r > v, 1'b1);
    end
    apb(1'b1, OFF_STATUS, {16'h0, SVC_ARM});
    apb(1'b1, OFF_STATUS, {16'h0, SVC_DONE});
    wait_fire(d);
    chk("bus_timeout", d, bus_wait(BUS_LAST_1));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("cause_flag", r[WDOG_FLAG_POS], 1'b1);
    apb(1'b0, OFF_OPT1, 32'h0);
    chk("defaults_back", r[1:0], TSEL_RST);
    other_reset <= 1'b1;
    @(posedge clk);
    other_reset <= 1'b0;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("cause_cleared", r[WDOG_FLAG_POS], 1'b0);
    apb(1'b1, OFF_OPT1, 32'h1);
    apb(1'b1, OFF_OPT2, 32'h3);
    idle(6100);
    apb(1'b1, OFF_STATUS, {16'h0, SVC_ARM});
    fire_next("early_service");
    apb(1'b1, OFF_OPT1, 32'h1);
    apb(1'b1, OFF_OPT2, 32'h3);
    f = fires;
    idle(6200);
    apb(1'b1, OFF_STATUS, {16'h0, SVC_ARM});
    apb(1'b1, OFF_STATUS, {16'h0, SVC_DONE});
    idle(2);
    chk("late_service", fires, f);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h0 : $random(seed);
      if (v[15:0] == SVC_ARM || v[15:0] == SVC_DONE) v[8] = ~v[8];
      apb(1'b1, OFF_STATUS, v);
      fire_next("illegal_value");
    end
    apb(1'b1, OFF_OPT1, 32'h1);
    apb(1'b1, OFF_OPT2, 32'h2);
    f = fires;
    apb(1'b1, OFF_STATUS, {16'h0, SVC_ARM});
    apb(1'b1, OFF_STATUS, {16'h0, SVC_DONE});
    idle(2);
    chk("no_window_lpo", fires, f);
    wait_fire(d);
    chk("lpo_timeout", d >= 1220 && d <= 1300, 1'b1);
    idle(400);
    stop_mode <= 1'b1;
    idle(5);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("lpo_cleared", r, 32'h0);
    stop_mode <= 1'b0;
    idle(100);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("lpo_from_zero", r < 4, 1'b1);
    apb(1'b1, OFF_OPT1, 32'h0);
    apb(1'b1, OFF_OPT2, 32'h1);
    f = fires;
    apb(1'b1, OFF_STATUS, 32'h1234);
    idle(9000);
    chk("disabled", fires, f);
    conclude();
  end
endmodule // windowed_service_watchdog_tb

`default_nettype wire
